// ===== rtl/adc_mon_pkg.sv
// shared constants and types of the multichannel monitor
package adc_mon_pkg;

	// ----------------------------------------------------------------
	// channels and codes
	// ----------------------------------------------------------------
	localparam int NUM_CH      = 15;
	localparam int CH_W        = 4;
	localparam int CODE_W      = 8;
	localparam int CODE_LSB_MV = 10;
	localparam int CODE_LO_MV  = 1000;
	localparam int CODE_HI_MV  = 3560;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS           = 100;
	localparam int SLOT_NS          = 600000;
	localparam int SLOT_CYC         = SLOT_NS / CLK_NS;
	localparam int ALERT_PULSE_NS   = 50000;
	localparam int ALERT_PULSE_CYC  = ALERT_PULSE_NS / CLK_NS;
	localparam int ALERT_PERIOD_NS  = 2000000000;
	localparam int ALERT_PERIOD_CYC = ALERT_PERIOD_NS / CLK_NS;
	localparam int ADDR_LATCH_NS    = 1000000;
	localparam int ADDR_LATCH_CYC   = ADDR_LATCH_NS / CLK_NS;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] THR_BASE = 8'h00;
	localparam logic [7:0] RES_BASE = 8'h0f;
	localparam logic [7:0] RES_LAST = 8'h1d;
	localparam logic [7:0] FLAG_LO  = 8'h1e;
	localparam logic [7:0] FLAG_HI  = 8'h1f;
	localparam logic [7:0] REG_RST  = 8'h00;

	// ----------------------------------------------------------------
	// slave address selection
	// ----------------------------------------------------------------
	localparam logic [6:0] ADDR_BASE      = 7'h70;
	localparam logic [6:0] ADDR_DEFAULT   = 7'h7e;
	localparam logic [6:0] ADDR_PCT_FIRST = 7'h1e;
	localparam logic [6:0] ADDR_PCT_STEP  = 7'h0a;
	localparam int         ADDR_SLOTS     = 8;

	typedef struct packed {
		logic [CH_W-1:0]   ch;
		logic [CODE_W-1:0] code;
	} result_upd_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK  = 3'b010,
		ST_RX   = 3'b011,
		ST_TX   = 3'b100,
		ST_RACK = 3'b101
	} link_state_e;

endpackage : adc_mon_pkg

// ===== rtl/sync_agree.sv
// three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/10ps
module sync_agree #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	// data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= d_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a bit that is still settling keeps its old value
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q_o <= '0;
		end else begin
			q_o <= (stage2 & stage3) | (q_o & (stage2 ^ stage3));
		end
	end
endmodule : sync_agree

// ===== rtl/multichannel_adc_monitor_i2c.sv
// scan, threshold alert, address strap and two-wire slave of the channel monitor
// ----------------------------------------------------------------
// Contract
// - idle in reset, start scanning after release
// - fifteen channels in turn, 0.6 ms slots
// - results are 8-bit codes, 10 mV steps
// - result below threshold pulls alert pin low
// - each alert pulse lasts 50 us
// - alert pulses repeat every 2 s
// - pin level fraction selects one of eight addresses
// - host reaches registers only over two-wire slave
// - data line changes only while clock low
// - thresholds 0x00-0x0e, results 0x0f-0x1d, reset zero
// - alert flags at 0x1e and 0x1f
// - pin at supply gives address 0x7e
// ----------------------------------------------------------------
`timescale 1ns/10ps
module multichannel_adc_monitor_i2c
	import adc_mon_pkg::*;
#(
	parameter int SLOT_CYCLES  = SLOT_CYC,
	parameter int PERIOD_CYCLES = ALERT_PERIOD_CYC,
	parameter int LATCH_CYCLES = ADDR_LATCH_CYC
) (
	// system clock and reset
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	// link clock
	input  wire logic              link_clk_i,
	// converter front end
	output logic      [CH_W-1:0]   adc_sel_o,
	input  wire logic [CODE_W-1:0] adc_code_i,
	// alert/address pin
	input  wire logic [6:0]        addr_pct_i,
	output logic                   alert_o,
	output logic                   alert_oe_o,
	// two-wire pins
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_o,
	// status
	output logic      [6:0]        dev_addr_o,
	output logic                   addr_valid_o
);
	// ----------------------------------------------------------------
	// channel scan (system clock)
	// ----------------------------------------------------------------
	logic [31:0]  slot_cnt;
	logic         slot_end;
	result_upd_s  upd;
	logic         upd_tgl;

	assign slot_end = (slot_cnt == 32'(SLOT_CYCLES - 1));

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			slot_cnt <= '0;
		end else begin
			slot_cnt <= slot_end ? '0 : slot_cnt + 32'd1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			adc_sel_o <= '0;
		end else if (slot_end) begin
			adc_sel_o <= (adc_sel_o == CH_W'(NUM_CH - 1)) ? '0 : adc_sel_o + 4'h1;
		end
	end

	// the word is held for a whole slot, far longer than the toggle takes to cross
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			upd     <= '0;
			upd_tgl <= 1'b0;
		end else if (slot_end) begin
			upd.ch   <= adc_sel_o;
			upd.code <= adc_code_i;
			upd_tgl  <= ~upd_tgl;
		end
	end

	// ----------------------------------------------------------------
	// address strap (system clock)
	// ----------------------------------------------------------------
	logic [31:0] latch_cnt;
	logic [6:0]  addr_dec;

	always_comb begin
		addr_dec = ADDR_BASE;
		for (int k = 0; k < ADDR_SLOTS - 1; k++) begin
			if (addr_pct_i >= ADDR_PCT_FIRST + 7'(k) * ADDR_PCT_STEP) begin
				addr_dec = ADDR_BASE + 7'(2 * (k + 1));
			end
		end
	end

	// the strap is read once; the pin is free for alerts afterwards
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			latch_cnt    <= '0;
			addr_valid_o <= 1'b0;
			dev_addr_o   <= ADDR_DEFAULT;
		end else if (!addr_valid_o) begin
			latch_cnt <= latch_cnt + 32'd1;
			if (latch_cnt == 32'(LATCH_CYCLES - 1)) begin
				addr_valid_o <= 1'b1;
				dev_addr_o   <= addr_dec;
			end
		end
	end

	// ----------------------------------------------------------------
	// alert pulses (system clock)
	// ----------------------------------------------------------------
	logic        alert_any_l;
	logic        alert_any;
	logic        alerting;
	logic [31:0] per_cnt;

	sync_agree #(.W(1)) u_sync_alert (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.d_i    (alert_any_l),
		.q_o    (alert_any)
	);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			alerting <= 1'b0;
			per_cnt  <= '0;
		end else if (!(alert_any && addr_valid_o)) begin
			alerting <= 1'b0;
			per_cnt  <= '0;
		end else if (!alerting) begin
			alerting <= 1'b1;
			per_cnt  <= '0;
		end else begin
			per_cnt <= (per_cnt == 32'(PERIOD_CYCLES - 1)) ? '0 : per_cnt + 32'd1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			alert_oe_o <= 1'b0;
		end else begin
			alert_oe_o <= alert_any && addr_valid_o && alerting
				&& (per_cnt < 32'(ALERT_PULSE_CYC));
		end
	end

	assign alert_o = 1'b0;

	// ----------------------------------------------------------------
	// link crossings
	// ----------------------------------------------------------------
	logic [1:0] pins_f;
	logic       scl_f;
	logic       sda_f;
	logic       scl_d;
	logic       sda_d;
	logic       tgl_f;
	logic       tgl_d;
	logic       addr_ok_l;

	sync_agree #(.W(2)) u_sync_pins (
		.clk_i  (link_clk_i),
		.rstn_i (rstn_i),
		.d_i    (~{scl_i, sda_i}),
		.q_o    (pins_f)
	);

	sync_agree #(.W(1)) u_sync_tgl (
		.clk_i  (link_clk_i),
		.rstn_i (rstn_i),
		.d_i    (upd_tgl),
		.q_o    (tgl_f)
	);

	sync_agree #(.W(1)) u_sync_addr (
		.clk_i  (link_clk_i),
		.rstn_i (rstn_i),
		.d_i    (addr_valid_o),
		.q_o    (addr_ok_l)
	);

	// carried inverted so the cleared filter means an idle, high bus: no false edge after reset
	assign scl_f = ~pins_f[1];
	assign sda_f = ~pins_f[0];

	// ----------------------------------------------------------------
	// register file (link clock)
	// ----------------------------------------------------------------
	logic [CODE_W-1:0] thr [NUM_CH];
	logic [CODE_W-1:0] res [NUM_CH];
	logic [NUM_CH-1:0] flags;
	logic              wr_en;
	logic [7:0]        ptr;
	logic [7:0]        shreg;
	logic [7:0]        rd_byte;

	always_ff @(posedge link_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tgl_d <= 1'b0;
			for (int i = 0; i < NUM_CH; i++) begin
				res[i] <= REG_RST;
			end
		end else begin
			tgl_d <= tgl_f;
			if (tgl_f != tgl_d && upd.ch < CH_W'(NUM_CH)) begin
				res[upd.ch] <= upd.code;
			end
		end
	end

	always_ff @(posedge link_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < NUM_CH; i++) begin
				thr[i] <= REG_RST;
			end
		end else if (wr_en && ptr < RES_BASE) begin
			thr[ptr[CH_W-1:0]] <= shreg;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			flags[i] = thr[i] > res[i];
		end
	end

	always_ff @(posedge link_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			alert_any_l <= 1'b0;
		end else begin
			alert_any_l <= |flags;
		end
	end

	// unmapped locations read as zero
	always_comb begin
		rd_byte = REG_RST;
		if (ptr < RES_BASE) begin
			rd_byte = thr[ptr[CH_W-1:0]];
		end else if (ptr <= RES_LAST) begin
			rd_byte = res[CH_W'(ptr - RES_BASE)];
		end else if (ptr == FLAG_LO) begin
			rd_byte = flags[7:0];
		end else if (ptr == FLAG_HI) begin
			rd_byte = {1'b0, flags[NUM_CH-1:8]};
		end
	end

	// ----------------------------------------------------------------
	// two-wire slave (link clock)
	// ----------------------------------------------------------------
	link_state_e state;
	logic [3:0]  bitn;
	logic        rd_mode;
	logic        got_ptr;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;

	assign scl_rise = scl_f && !scl_d;
	assign scl_fall = !scl_f && scl_d;
	assign start_c  = scl_f && scl_d && sda_d && !sda_f;
	assign stop_c   = scl_f && scl_d && !sda_d && sda_f;
	assign sda_o    = 1'b0;
	assign wr_en    = scl_fall && state == ST_RX && bitn == 4'h8 && got_ptr;

	always_ff @(posedge link_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_f;
			sda_d <= sda_f;
		end
	end

	// the data line is only moved on a seen falling clock edge
	always_ff @(posedge link_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state    <= ST_IDLE;
			bitn     <= '0;
			shreg    <= '0;
			ptr      <= '0;
			rd_mode  <= 1'b0;
			got_ptr  <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (start_c) begin
			state    <= ST_ADDR;
			bitn     <= '0;
			got_ptr  <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (stop_c) begin
			state    <= ST_IDLE;
			sda_oe_o <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					sda_oe_o <= 1'b0;
				end
				ST_ADDR, ST_RX: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_f};
						bitn  <= bitn + 4'h1;
					end else if (scl_fall && bitn == 4'h8) begin
						state    <= ST_ACK;
						sda_oe_o <= 1'b1;
						if (state == ST_ADDR) begin
							rd_mode <= shreg[0];
							if (!addr_ok_l || shreg[7:1] != dev_addr_o) begin
								state    <= ST_IDLE;
								sda_oe_o <= 1'b0;
							end
						end else if (!got_ptr) begin
							ptr     <= shreg;
							got_ptr <= 1'b1;
						end else begin
							ptr <= ptr + 8'h01;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bitn <= '0;
						if (rd_mode) begin
							state    <= ST_TX;
							shreg    <= rd_byte;
							sda_oe_o <= ~rd_byte[7];
						end else begin
							state    <= ST_RX;
							sda_oe_o <= 1'b0;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bitn <= bitn + 4'h1;
					end else if (scl_fall) begin
						if (bitn == 4'h8) begin
							state    <= ST_RACK;
							sda_oe_o <= 1'b0;
							// step now so the next byte is ready if the master acks
							ptr      <= ptr + 8'h01;
						end else begin
							shreg    <= {shreg[6:0], 1'b0};
							sda_oe_o <= ~shreg[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						rd_mode <= !sda_f;
					end else if (scl_fall) begin
						bitn <= '0;
						if (rd_mode) begin
							state    <= ST_TX;
							shreg    <= rd_byte;
							sda_oe_o <= ~rd_byte[7];
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				default: begin
					state    <= ST_IDLE;
					sda_oe_o <= 1'b0;
				end
			endcase
		end
	end
endmodule : multichannel_adc_monitor_i2c

// ===== dv/multichannel_adc_monitor_i2c_sva.sv
// port checker of the channel monitor
`timescale 1ns/10ps
module multichannel_adc_monitor_i2c_sva
	import adc_mon_pkg::*;
#(
	parameter int SLOT_CYCLES   = SLOT_CYC,
	parameter int PERIOD_CYCLES = ALERT_PERIOD_CYC,
	parameter int LATCH_CYCLES  = ADDR_LATCH_CYC
) (
	// clocks and reset
	input  wire logic            clk_i,
	input  wire logic            rstn_i,
	input  wire logic            link_clk_i,
	// watched ports
	input  wire logic [CH_W-1:0] adc_sel_o,
	input  wire logic            alert_oe_o,
	input  wire logic            scl_i,
	input  wire logic            sda_oe_o,
	input  wire logic [6:0]      dev_addr_o,
	input  wire logic            addr_valid_o
);
	// ----
	// helper counters
	// ----
	logic [31:0] slot_cnt;
	logic [31:0] high_cnt;
	logic [31:0] up_cnt;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) slot_cnt <= '0;
		else slot_cnt <= $changed(adc_sel_o) ? '0 : slot_cnt + 1;
	end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) high_cnt <= '0;
		else high_cnt <= alert_oe_o ? high_cnt + 1 : '0;
	end
	// saturates so the counter never wraps in long runs
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) up_cnt <= '0;
		else if (up_cnt < LATCH_CYCLES + 4) up_cnt <= up_cnt + 1;
	end

	// ----
	// assertions
	// ----
	AST_SCAN_STEP: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$changed(adc_sel_o) |-> adc_sel_o == (($past(adc_sel_o) == 4'he) ? 4'h0
			: $past(adc_sel_o) + 4'h1)) else $error("scan order broken");
	AST_SCAN_RANGE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		adc_sel_o <= 4'he) else $error("channel out of range");
	AST_SLOT_LEN: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$changed(adc_sel_o) |-> slot_cnt >= SLOT_CYCLES - 2 && slot_cnt <= SLOT_CYCLES)
		else $error("slot length wrong");
	AST_SCAN_RUNS: assert property (@(posedge clk_i) disable iff (!rstn_i)
		slot_cnt <= SLOT_CYCLES) else $error("scan stalled");
	AST_PULSE_MAX: assert property (@(posedge clk_i) disable iff (!rstn_i)
		alert_oe_o |-> high_cnt < ALERT_PULSE_CYC) else $error("alert pulse too long");
	AST_ALERT_GATE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!addr_valid_o |-> !alert_oe_o) else $error("alert before address latch");
	AST_ADDR_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
		addr_valid_o |=> addr_valid_o && $stable(dev_addr_o)) else $error("address moved");
	AST_ADDR_TIME: assert property (@(posedge clk_i) disable iff (!rstn_i)
		up_cnt >= LATCH_CYCLES + 2 |-> addr_valid_o) else $error("address latch late");
	AST_ADDR_EARLY: assert property (@(posedge clk_i) disable iff (!rstn_i)
		up_cnt < LATCH_CYCLES - 2 |-> !addr_valid_o && dev_addr_o == ADDR_DEFAULT)
		else $error("address early or not default");
	AST_ADDR_LEGAL: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(addr_valid_o) |-> dev_addr_o[6:4] == 3'h7 && !dev_addr_o[0])
		else $error("address not in set");
	AST_SDA_SCL: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
		$changed(sda_oe_o) |-> !scl_i && !$past(scl_i)) else $error("data moved, clock high");
endmodule : multichannel_adc_monitor_i2c_sva

bind multichannel_adc_monitor_i2c multichannel_adc_monitor_i2c_sva #(
	.SLOT_CYCLES(SLOT_CYCLES),
	.PERIOD_CYCLES(PERIOD_CYCLES),
	.LATCH_CYCLES(LATCH_CYCLES)
) u_sva (
	.clk_i(clk_i),
	.rstn_i(rstn_i),
	.link_clk_i(link_clk_i),
	.adc_sel_o(adc_sel_o),
	.alert_oe_o(alert_oe_o),
	.scl_i(scl_i),
	.sda_oe_o(sda_oe_o),
	.dev_addr_o(dev_addr_o),
	.addr_valid_o(addr_valid_o)
);

// ===== dv/i2c_host_model.sv
// two-wire bus master model
`timescale 1ns/10ps
module i2c_host_model (
	// timing clock and resolved data line
	input  wire logic lclk_i,
	input  wire logic sda_i,
	// open-drain pulls
	output logic      scl_low_o,
	output logic      sda_low_o
);
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	// quarter bit, slow enough for the slave's input filter
	task automatic tq();
		repeat (16) @(posedge lclk_i);
		#1;
	endtask : tq
	task automatic bit_io(input logic b, output logic r);
		sda_low_o = !b;
		tq();
		scl_low_o = 1'b0;
		tq();
		r = sda_i;
		tq();
		scl_low_o = 1'b1;
		tq();
	endtask : bit_io
	task automatic start();
		sda_low_o = 1'b0;
		tq();
		scl_low_o = 1'b0;
		tq();
		sda_low_o = 1'b1;
		tq();
		scl_low_o = 1'b1;
		tq();
	endtask : start
	task automatic stop();
		sda_low_o = 1'b1;
		tq();
		scl_low_o = 1'b0;
		tq();
		sda_low_o = 1'b0;
		tq();
	endtask : stop
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask : wbyte
	task automatic rbyte(input logic nack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(nack, r);
	endtask : rbyte
endmodule : i2c_host_model

// ===== dv/multichannel_adc_monitor_i2c_test.sv
// bench of the channel monitor
`timescale 1ns/10ps
module multichannel_adc_monitor_i2c_test
	import adc_mon_pkg::*;
;
	localparam int SLOT = 20;
	localparam int PER  = 2000;
	localparam int LAT  = 50;
	logic              clk_i;
	logic              rstn_i;
	logic              link_clk_i;
	logic [CH_W-1:0]   adc_sel_o;
	logic [CODE_W-1:0] adc_code_i;
	logic [6:0]        addr_pct_i;
	logic              alert_oe_o;
	logic              alert_o;
	logic              sda_o;
	logic              sda_oe_o;
	logic [6:0]        dev_addr_o;
	logic              addr_valid_o;
	logic              scl_low;
	logic              sda_low;
	wire logic         scl_i = !scl_low;
	wire logic         sda_i = !(sda_low | (sda_oe_o & !sda_o));
	int                bad_count;
	int                compares;
	logic [7:0]        d;
	logic [7:0]        d2;
	logic [3:0]        ak;
	logic [31:0]       n;
	logic              a;

	multichannel_adc_monitor_i2c #(.SLOT_CYCLES(SLOT), .PERIOD_CYCLES(PER), .LATCH_CYCLES(LAT))
	u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .link_clk_i(link_clk_i), .adc_sel_o(adc_sel_o),
		.adc_code_i(adc_code_i), .addr_pct_i(addr_pct_i), .alert_o(alert_o),
		.alert_oe_o(alert_oe_o), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .dev_addr_o(dev_addr_o), .addr_valid_o(addr_valid_o));
	i2c_host_model u_host (.lclk_i(link_clk_i), .sda_i(sda_i), .scl_low_o(scl_low),
		.sda_low_o(sda_low));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		link_clk_i = 1'b0;
		#7;
		forever #32 link_clk_i = ~link_clk_i;
	end
	// each channel sees its own fixed code
	always @(posedge clk_i) #1 adc_code_i = 8'h11 * adc_sel_o + 8'h05;

	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rst(input logic [6:0] pct);
		rstn_i = 1'b0;
		addr_pct_i = pct;
		repeat (16) @(posedge clk_i);
		#1;
		chk({addr_valid_o, dev_addr_o}, {1'b0, ADDR_DEFAULT});
		chk({alert_o, sda_o, alert_oe_o, sda_oe_o, adc_sel_o}, '0);
		rstn_i = 1'b1;
	endtask : rst
	task automatic meas(input logic lvl, output logic [31:0] cnt);
		cnt = 0;
		while (alert_oe_o === lvl && cnt < PER + 10) begin
			@(posedge clk_i);
			#1;
			cnt++;
		end
	endtask : meas
	task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] val);
		logic a1, a2, a3;
		u_host.start();
		u_host.wbyte({ADDR_DEFAULT, 1'b0}, a1);
		u_host.wbyte(ptr, a2);
		u_host.wbyte(val, a3);
		u_host.stop();
		chk({a1, a2, a3}, 3'b111);
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] ptr, output logic [7:0] val);
		logic a1, a2, a3;
		u_host.start();
		u_host.wbyte({ADDR_DEFAULT, 1'b0}, a1);
		u_host.wbyte(ptr, a2);
		u_host.start();
		u_host.wbyte({ADDR_DEFAULT, 1'b1}, a3);
		u_host.rbyte(1'b1, val);
		u_host.stop();
		chk({a1, a2, a3}, 3'b111);
	endtask : reg_rd

	initial begin
		adc_code_i = '0;
		for (int i = 0; i < ADDR_SLOTS; i++) begin
			rst(7'(i == ADDR_SLOTS - 1 ? 100 : 25 + 10 * i));
			repeat (LAT + 8) @(posedge clk_i);
			#1;
			chk(dev_addr_o, ADDR_BASE + 7'(2 * i));
			addr_pct_i = 7'h00;
			repeat (8) @(posedge clk_i);
			#1;
			chk({addr_valid_o, dev_addr_o}, {1'b1, ADDR_BASE + 7'(2 * i)});
		end
		repeat (SLOT * 16) @(posedge clk_i);
		for (int i = 0; i < NUM_CH; i++) begin
			reg_rd(RES_BASE + 8'(i), d);
			chk(d, 8'h11 * i + 8'h05);
		end
		u_host.start();
		u_host.wbyte({ADDR_BASE, 1'b0}, a);
		u_host.stop();
		chk(a, 1'b0);
		reg_wr(THR_BASE, 8'h5a);
		reg_wr(RES_BASE, 8'h00);
		reg_wr(RES_BASE - 8'h01, 8'hff);
		reg_rd(THR_BASE, d);
		chk(d, 8'h5a);
		reg_rd(RES_BASE, d);
		chk(d, 8'h05);
		reg_rd(8'h20, d);
		chk(d, 8'h00);
		reg_rd(FLAG_LO, d);
		chk(d, 8'h01);
		reg_rd(FLAG_HI, d);
		chk(d, 8'h40);
		meas(1'b1, n);
		meas(1'b0, n);
		meas(1'b1, n);
		chk(n, ALERT_PULSE_CYC);
		meas(1'b0, n);
		chk(n, PER - ALERT_PULSE_CYC);
		reg_wr(THR_BASE, 8'h00);
		reg_wr(RES_BASE - 8'h01, 8'h00);
		meas(1'b1, n);
		meas(1'b0, n);
		chk(n, PER + 10);
		// burst write then burst read: pointer steps, master ack continues
		u_host.start();
		u_host.wbyte({ADDR_DEFAULT, 1'b0}, ak[0]);
		u_host.wbyte(THR_BASE + 8'h01, ak[1]);
		u_host.wbyte(8'h10, ak[2]);
		u_host.wbyte(8'h20, ak[3]);
		u_host.stop();
		chk(ak, 4'hf);
		u_host.start();
		u_host.wbyte({ADDR_DEFAULT, 1'b0}, ak[0]);
		u_host.wbyte(THR_BASE + 8'h01, ak[1]);
		u_host.start();
		u_host.wbyte({ADDR_DEFAULT, 1'b1}, ak[2]);
		u_host.rbyte(1'b0, d);
		u_host.rbyte(1'b1, d2);
		u_host.stop();
		chk({ak[2:0], d, d2}, {3'b111, 8'h10, 8'h20});
		stop_test();
	end
	initial begin
		repeat (90000) @(posedge clk_i);
		bad_count++;
		stop_test();
	end
endmodule : multichannel_adc_monitor_i2c_test
